// ### verilog/apu_pkg.sv
// Summary of operation
// - Preset loads stored position from preset word pair
// - No preset while sensor fault present
// - Host ready raises online flag; preset needs online
// - Preset only when inhibit word pair is zero
// - Preset taken on command rising edge
// - New position in effect within 2 ms
// - Device occupies thirty-two discrete I/O points
// - Control starts once host ready asserted
// - Control halts when host ready drops
// - Error clear must be held 12 ms
// - Sensor-fault flag set on sensor error
// - Fault-detected flag set on any error
// - Error number stored binary in word 7
// - Recognised error clear clears error state
// - Position kept binary and updated continuously
package apu_pkg;
	localparam int NAX = 2;
	localparam int IO_POINTS = 32;
	localparam int ADDR_W = 11;
	localparam int POS_W = 32;
	localparam int WORD_W = 16;
	// Axis 2 base address and buffer word offsets within one axis
	localparam logic [10:0] AX2_BASE = 11'h3E8;
	localparam logic [10:0] OFS_SENS_LO = 11'h000;
	localparam logic [10:0] OFS_SENS_HI = 11'h001;
	localparam logic [10:0] OFS_CW_LO = 11'h002;
	localparam logic [10:0] OFS_CW_HI = 11'h003;
	localparam logic [10:0] OFS_CCW_LO = 11'h004;
	localparam logic [10:0] OFS_CCW_HI = 11'h005;
	localparam logic [10:0] OFS_STATUS = 11'h006;
	localparam logic [10:0] OFS_ERR = 11'h007;
	localparam logic [10:0] OFS_PRESET_LO = 11'h2B2;
	localparam logic [10:0] OFS_PRESET_HI = 11'h2B3;
	localparam logic [10:0] OFS_INHIBIT_LO = 11'h2B6;
	localparam logic [10:0] OFS_INHIBIT_HI = 11'h2B7;
	localparam logic [10:0] OFS_AXIS_EN = 11'h2BE;
	// Discrete point positions
	localparam int Y_HOST_READY = 16;
	localparam int Y_PRESET1 = 19;
	localparam int Y_PRESET2 = 22;
	localparam int Y_ERR_CLEAR = 28;
	localparam int X_ONLINE = 1;
	localparam int X_SFLT1 = 4;
	localparam int X_FLT1 = 5;
	localparam int X_SFLT2 = 8;
	localparam int X_FLT2 = 9;
	// Error numbers
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_RO_BASE = 16'h000A;
	localparam logic [15:0] ERR_SENSOR = 16'h0016;
	// Reset values
	localparam logic AXIS_EN_RST = 1'b1;
	// Timing
	localparam int CLK_HZ = 125_000_000;
	localparam int CLR_TIME_MS = 12;
	localparam int CLR_CYC = CLR_TIME_MS * (CLK_HZ / 1000);
	localparam int CLR_CNT_W = 21;

	typedef struct packed {
		logic online;
		logic [NAX-1:0] cmd_d;
		logic [NAX-1:0] en;
		logic [NAX-1:0] sflt;
		logic [NAX-1:0][POS_W-1:0] sens;
		logic [NAX-1:0][POS_W-1:0] cw;
		logic [NAX-1:0][POS_W-1:0] ccw;
		logic [NAX-1:0][POS_W-1:0] off_cw;
		logic [NAX-1:0][POS_W-1:0] off_ccw;
		logic [NAX-1:0][POS_W-1:0] preset;
		logic [NAX-1:0][POS_W-1:0] inhibit;
		logic [NAX-1:0][WORD_W-1:0] err;
		logic [CLR_CNT_W-1:0] clr_cnt;
		logic [WORD_W-1:0] rdata;
	} apu_state_s;
endpackage : apu_pkg

// ### verilog/apu_preset_unit.sv
module apu_preset_unit
	import apu_pkg::*;
#(
	parameter int CLR_CYCLES = CLR_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [IO_POINTS-1:0] y_points,
	output logic [IO_POINTS-1:0] x_points,
	input wire logic [ADDR_W-1:0] buf_addr,
	input wire logic buf_wr,
	input wire logic buf_rd,
	input wire logic [WORD_W-1:0] buf_wdata,
	output logic [WORD_W-1:0] buf_rdata,
	input wire logic [POS_W-1:0] sens_pos_axis1,
	input wire logic [POS_W-1:0] sens_pos_axis2,
	input wire logic sens_err_axis1,
	input wire logic sens_err_axis2
);
	localparam logic [CLR_CNT_W-1:0] CLR_LAST = CLR_CNT_W'(CLR_CYCLES - 1);

	apu_state_s s_ff;
	apu_state_s nxt_s;

	// Splits a buffer word address into axis and per-axis offset
	function automatic logic [ADDR_W:0] split_addr(input logic [ADDR_W-1:0] a);
		if (a >= AX2_BASE) begin
			split_addr = {1'b1, ADDR_W'(a - AX2_BASE)};
		end else begin
			split_addr = {1'b0, a};
		end
	endfunction : split_addr

	// Picks one 16-bit half of a 32-bit value
	function automatic logic [WORD_W-1:0] half(input logic [POS_W-1:0] v, input logic hi);
		half = hi ? v[POS_W-1:WORD_W] : v[WORD_W-1:0];
	endfunction : half

	logic [NAX-1:0][POS_W-1:0] sens;
	logic [NAX-1:0] serr;
	logic [NAX-1:0] cmd;
	logic [ADDR_W:0] dax;
	logic ax;
	logic [ADDR_W-1:0] ofs;
	logic clr_now;
	logic [NAX-1:0] edge_seen;
	logic [NAX-1:0] may_preset;

	assign sens[0] = sens_pos_axis1;
	assign sens[1] = sens_pos_axis2;
	assign serr = {sens_err_axis2, sens_err_axis1};
	assign cmd = {y_points[Y_PRESET2], y_points[Y_PRESET1]};

	always_comb begin
		nxt_s = s_ff;
		dax = split_addr(buf_addr);
		ax = dax[ADDR_W];
		ofs = dax[ADDR_W-1:0];
		nxt_s.online = y_points[Y_HOST_READY];
		nxt_s.cmd_d = cmd;
		edge_seen = cmd & ~s_ff.cmd_d;
		// Clear must be seen steadily; short pulses are dropped
		clr_now = 1'b0;
		if (s_ff.online && y_points[Y_ERR_CLEAR]) begin
			if (s_ff.clr_cnt != CLR_LAST + CLR_CNT_W'(1)) begin
				nxt_s.clr_cnt = s_ff.clr_cnt + CLR_CNT_W'(1);
			end
			clr_now = (s_ff.clr_cnt == CLR_LAST);
		end else begin
			nxt_s.clr_cnt = '0;
		end
		for (int i = 0; i < NAX; i++) begin
			may_preset[i] = s_ff.online && s_ff.en[i] && !serr[i]
				&& s_ff.err[i] != ERR_SENSOR
				&& s_ff.inhibit[i] == '0;
			// Clear first so an error arriving now still sets
			if (clr_now) begin
				nxt_s.err[i] = ERR_NONE;
			end
			if (s_ff.online && s_ff.en[i]) begin
				nxt_s.sens[i] = sens[i];
				nxt_s.cw[i] = s_ff.off_cw[i] + sens[i];
				nxt_s.ccw[i] = s_ff.off_ccw[i] - sens[i];
				nxt_s.sflt[i] = serr[i];
				if (serr[i]) begin
					nxt_s.err[i] = ERR_SENSOR;
				end
				// Offsets re-anchor the counts so tracking continues from the preset
				if (edge_seen[i] && may_preset[i]) begin
					nxt_s.off_cw[i] = s_ff.preset[i] - sens[i];
					nxt_s.off_ccw[i] = s_ff.preset[i] + sens[i];
					nxt_s.cw[i] = s_ff.preset[i];
					nxt_s.ccw[i] = s_ff.preset[i];
				end
			end else begin
				nxt_s.sflt[i] = 1'b0;
			end
		end
		if (buf_wr) begin
			unique case (ofs)
				OFS_PRESET_LO: begin
					nxt_s.preset[ax][WORD_W-1:0] = buf_wdata;
				end
				OFS_PRESET_HI: begin
					nxt_s.preset[ax][POS_W-1:WORD_W] = buf_wdata;
				end
				OFS_INHIBIT_LO: begin
					nxt_s.inhibit[ax][WORD_W-1:0] = buf_wdata;
				end
				OFS_INHIBIT_HI: begin
					nxt_s.inhibit[ax][POS_W-1:WORD_W] = buf_wdata;
				end
				OFS_AXIS_EN: begin
					nxt_s.en[ax] = buf_wdata[0];
				end
				OFS_SENS_LO, OFS_SENS_HI, OFS_CW_LO, OFS_CW_HI,
				OFS_CCW_LO, OFS_CCW_HI, OFS_STATUS: begin
					// Read-only area written while online
					if (s_ff.online) begin
						nxt_s.err[ax] = ERR_RO_BASE + WORD_W'(ofs);
					end
				end
				default: begin
				end
			endcase
		end
		if (buf_rd) begin
			unique case (ofs)
				OFS_SENS_LO, OFS_SENS_HI: begin
					nxt_s.rdata = half(s_ff.sens[ax], ofs[0]);
				end
				OFS_CW_LO, OFS_CW_HI: begin
					nxt_s.rdata = half(s_ff.cw[ax], ofs[0]);
				end
				OFS_CCW_LO, OFS_CCW_HI: begin
					nxt_s.rdata = half(s_ff.ccw[ax], ofs[0]);
				end
				OFS_STATUS: begin
					nxt_s.rdata = {15'h0000, s_ff.sflt[ax]};
				end
				OFS_ERR: begin
					nxt_s.rdata = s_ff.err[ax];
				end
				OFS_PRESET_LO, OFS_PRESET_HI: begin
					nxt_s.rdata = half(s_ff.preset[ax], ofs[0]);
				end
				OFS_INHIBIT_LO, OFS_INHIBIT_HI: begin
					nxt_s.rdata = half(s_ff.inhibit[ax], ofs[0]);
				end
				OFS_AXIS_EN: begin
					nxt_s.rdata = {15'h0000, s_ff.en[ax]};
				end
				default: begin
					nxt_s.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_ff <= '0;
			s_ff.en <= {NAX{AXIS_EN_RST}};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Fault-detected flags follow the stored error numbers, sensor-fault flags the sflt bits
	always_comb begin
		x_points = '0;
		x_points[X_ONLINE] = s_ff.online;
		x_points[X_SFLT1] = s_ff.sflt[0];
		x_points[X_SFLT2] = s_ff.sflt[1];
		x_points[X_FLT1] = s_ff.err[0] != ERR_NONE;
		x_points[X_FLT2] = s_ff.err[1] != ERR_NONE;
	end

	assign buf_rdata = s_ff.rdata;
endmodule : apu_preset_unit

// ### bench/apu_host.sv
module apu_host
	import apu_pkg::*;
#(
	parameter int GAP = 4
) (
	input wire logic clk,
	output logic [IO_POINTS-1:0] y_points,
	output logic [ADDR_W-1:0] buf_addr,
	output logic buf_wr,
	output logic buf_rd,
	output logic [WORD_W-1:0] buf_wdata,
	input wire logic [WORD_W-1:0] buf_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		y_points = 32'h0000_0000;
		buf_addr = 11'h000;
		buf_wr = 1'b0;
		buf_rd = 1'b0;
		buf_wdata = 16'h0000;
	end
	task set(input int b, input logic v);
		@(posedge clk);
		y_points[b] <= v;
	endtask : set
	// Gaps scaled down to keep run time short
	task pulse(input int b);
		repeat (GAP) @(posedge clk);
		set(b, 1'b1);
		set(b, 1'b0);
		repeat (GAP) @(posedge clk);
	endtask : pulse
	// Released lines show inverted values, not stale ones
	task wr(input logic [10:0] a, input logic [15:0] d);
		@(posedge clk);
		buf_addr <= a;
		buf_wdata <= d;
		buf_wr <= 1'b1;
		@(posedge clk);
		buf_wr <= 1'b0;
		buf_addr <= ~a;
		buf_wdata <= ~d;
	endtask : wr
	task rd(input logic [10:0] a, output logic [15:0] d);
		@(posedge clk);
		buf_addr <= a;
		buf_rd <= 1'b1;
		@(posedge clk);
		buf_rd <= 1'b0;
		buf_addr <= ~a;
		@(posedge clk);
		#1 d = buf_rdata;
	endtask : rd
endmodule : apu_host

// ### bench/apu_chk_properties.sv
module apu_chk
	import apu_pkg::*;
#(
	parameter int CLR_CYCLES = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [IO_POINTS-1:0] y_points,
	input wire logic [IO_POINTS-1:0] x_points,
	input wire logic buf_rd,
	input wire logic [WORD_W-1:0] buf_rdata,
	input wire logic sens_err_axis1,
	input wire logic sens_err_axis2
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_onl; y_points[Y_HOST_READY] |=> x_points[X_ONLINE]; endproperty
	a_onl: assert property (p_onl) else $error("online missing");
	property p_off; !y_points[Y_HOST_READY] |=> !x_points[X_ONLINE]; endproperty
	a_off: assert property (p_off) else $error("online stuck");
	property p_go; x_points[X_ONLINE] |-> $past(y_points[Y_HOST_READY]); endproperty
	a_go: assert property (p_go) else $error("online unasked");
	property p_sf1;
		x_points[X_ONLINE] && y_points[Y_HOST_READY] && sens_err_axis1
		|=> x_points[X_SFLT1] && x_points[X_FLT1];
	endproperty
	a_sf1: assert property (p_sf1) else $error("axis1 flags");
	property p_sf2;
		x_points[X_ONLINE] && y_points[Y_HOST_READY] && sens_err_axis2
		|=> x_points[X_SFLT2] && x_points[X_FLT2];
	endproperty
	a_sf2: assert property (p_sf2) else $error("axis2 flags");
	property p_io; (x_points & 32'hFFFF_FCCD) == 32'h0000_0000; endproperty
	a_io: assert property (p_io) else $error("spare point set");
	property p_rd; !buf_rd |=> $stable(buf_rdata); endproperty
	a_rd: assert property (p_rd) else $error("read data moved");
	property p_hold;
		x_points[X_FLT1] && x_points[X_ONLINE] && !y_points[Y_ERR_CLEAR]
		&& !$past(y_points[Y_ERR_CLEAR]) |=> x_points[X_FLT1];
	endproperty
	a_hold: assert property (p_hold) else $error("fault lost");
	cover property (x_points[X_ONLINE] && $rose(y_points[Y_PRESET1]));
	cover property (x_points[X_FLT1] ##1 !x_points[X_FLT1]);
	cover property (x_points[X_FLT2]);
endmodule : apu_chk

// ### bench/tb_top.sv
module tb_top;
	import apu_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, resetn = 1'b0, e1 = 1'b0, e2 = 1'b0, wr, rd;
	logic [31:0] s1 = 32'h0, s2 = 32'h0, x, y, r, p, lf = 32'h2A;
	logic [10:0] a, b;
	logic [15:0] wd, rdd, w;
	int fail_count = 0, checked = 0;
	apu_host h (.clk(clk), .y_points(y), .buf_addr(a), .buf_wr(wr), .buf_rd(rd),
		.buf_wdata(wd), .buf_rdata(rdd));
	apu_preset_unit #(.CLR_CYCLES(8)) dut (.clk(clk), .resetn(resetn), .y_points(y),
		.x_points(x), .buf_addr(a), .buf_wr(wr), .buf_rd(rd), .buf_wdata(wd),
		.buf_rdata(rdd), .sens_pos_axis1(s1), .sens_pos_axis2(s2),
		.sens_err_axis1(e1), .sens_err_axis2(e2));
	function logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	task chk(logic [31:0] g, logic [31:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	task wr32(logic [10:0] ad, logic [31:0] v);
		h.wr(ad, v[15:0]);
		h.wr(ad + 11'h001, v[31:16]);
	endtask : wr32
	task rd32(logic [10:0] ad, output logic [31:0] v);
		logic [15:0] lo, hi;
		h.rd(ad, lo);
		h.rd(ad + 11'h001, hi);
		v = {hi, lo};
	endtask : rd32
	task summarize;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	initial forever #4 clk = ~clk;
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		lf = nxt(lf);
		s1 <= lf;
		h.wr(OFS_AXIS_EN, 16'h0001);
		h.wr(AX2_BASE + OFS_AXIS_EN, 16'h0001);
		h.set(Y_HOST_READY, 1'b1);
		repeat (2) @(posedge clk);
		#1 chk(x[X_ONLINE], 1);
		for (int ax = 0; ax < 2; ax++) begin
			b = ax ? AX2_BASE : 11'h000;
			lf = nxt(lf);
			p = lf;
			wr32(b + OFS_PRESET_LO, p);
			h.pulse(ax ? Y_PRESET2 : Y_PRESET1);
			rd32(b + OFS_CW_LO, r);
			chk(r, p);
			rd32(b + OFS_CCW_LO, r);
			chk(r, p);
		end
		// Axis 2 from here until the read-only write on axis 1
		@(posedge clk);
		s2 <= s2 + 32'h5;
		rd32(b + OFS_CW_LO, r);
		chk(r, p + 32'h5);
		rd32(b + OFS_CCW_LO, r);
		chk(r, p - 32'h5);
		wr32(b + OFS_INHIBIT_LO, 32'h0001_0000);
		wr32(b + OFS_PRESET_LO, ~p);
		h.pulse(Y_PRESET2);
		rd32(b + OFS_CW_LO, r);
		chk(r, p + 32'h5);
		wr32(b + OFS_INHIBIT_LO, 32'h0);
		h.set(Y_PRESET2, 1'b1);
		wr32(b + OFS_PRESET_LO, p);
		rd32(b + OFS_CW_LO, r);
		chk(r, ~p);
		h.set(Y_PRESET2, 1'b0);
		// Write into read-only area while online raises its own error code
		h.wr(OFS_CW_LO, 16'h1234);
		h.rd(OFS_ERR, w);
		chk(w, ERR_RO_BASE + 16'h0002);
		chk({x[X_FLT1], x[X_SFLT1]}, 2'h2);
		@(posedge clk);
		e1 <= 1'b1;
		e2 <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk({x[X_FLT2], x[X_SFLT2], x[X_FLT1], x[X_SFLT1]}, 4'hF);
		h.rd(OFS_ERR, w);
		chk(w, ERR_SENSOR);
		h.pulse(Y_PRESET2);
		rd32(b + OFS_CW_LO, r);
		chk(r, ~p);
		@(posedge clk);
		e1 <= 1'b0;
		e2 <= 1'b0;
		// Short clear pulse must not drop the faults
		h.set(Y_ERR_CLEAR, 1'b1);
		repeat (3) @(posedge clk);
		h.set(Y_ERR_CLEAR, 1'b0);
		repeat (2) @(posedge clk);
		#1 chk({x[X_FLT2], x[X_FLT1]}, 2'h3);
		h.set(Y_ERR_CLEAR, 1'b1);
		repeat (12) @(posedge clk);
		h.set(Y_ERR_CLEAR, 1'b0);
		repeat (2) @(posedge clk);
		#1 chk({x[X_FLT2], x[X_SFLT2], x[X_FLT1], x[X_SFLT1]}, 4'h0);
		h.set(Y_HOST_READY, 1'b0);
		// Sensor moves only once online has dropped, so positions must freeze
		repeat (2) @(posedge clk);
		s2 <= s2 + 32'h7;
		#1 chk(x[X_ONLINE], 0);
		rd32(b + OFS_CW_LO, r);
		chk(r, ~p);
		summarize();
	end
endmodule : tb_top
bind apu_preset_unit apu_chk #(.CLR_CYCLES(CLR_CYCLES)) chk (.clk(clk), .resetn(resetn),
	.y_points(y_points), .x_points(x_points), .buf_rd(buf_rd), .buf_rdata(buf_rdata),
	.sens_err_axis1(sens_err_axis1), .sens_err_axis2(sens_err_axis2));
